// ==== logic/mmac_ctrl.sv ====
`include "mmac_defines.svh"
module mmac_ctrl
  import mmac_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic cmd_clear_i,
  input wire logic cmd_keep_i,
  input wire logic cmd_bcast_i,
  input wire logic conv_cycle_done_i,
  input wire logic acc_overflow_i,
  input wire logic shared_pin_i,
  output logic alert_pin_o,
  output logic alert_pin_oe_o,
  output logic conv_run_o,
  output logic [1:0] conv_rate_o,
  output logic acc_clear_o,
  output logic results_refresh_o
);
  mmac_mode_t mode_q, mode_d;
  logic [1:0] rate_q, rate_d;
  logic halt_q, halt_d;
  logic single_q, single_d;
  logic role_q, role_d;
  logic cc_en_q, cc_en_d;
  logic oflow_en_q, oflow_en_d;
  logic flag_q, flag_d;
  logic oflow_alert_q, oflow_alert_d;
  logic slow_s1_q, slow_s2_q;
  logic acc_clear_q, acc_clear_d;
  logic refresh_q, refresh_d;
  logic [1:0] rate_eff_q, rate_eff_d;
  logic oe_q, oe_d;
  logic [7:0] rdata_q, rdata_d;
  logic any_cmd, clr_cmd, wr_ctrl, slow_active, cc_pulse, alert_active;

  assign clr_cmd = cmd_clear_i | cmd_bcast_i;
  assign any_cmd = clr_cmd | cmd_keep_i;
  assign wr_ctrl = reg_wr_i & (reg_addr_i == `MMAC_CTRL_ADDR);
  // the slow input only counts while the pin is not an alert output
  assign slow_active = ~role_q & slow_s2_q;

  // pulse stretcher for conversion-done alerts; runs whatever the pin role is
  mmac_pulse_timer u_timer (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .start_i(conv_cycle_done_i & cc_en_q),
    .active_o(cc_pulse)
  );

  // overflow notification masks the done pulses entirely
  assign alert_active = oflow_en_q ? oflow_alert_q : (cc_en_q & cc_pulse);

  // next values for control bits, mode, alert state and pin
  always_comb begin
    mode_d = mode_q;
    rate_d = rate_q;
    halt_d = halt_q;
    single_d = single_q;
    role_d = role_q;
    cc_en_d = cc_en_q;
    oflow_en_d = oflow_en_q;
    flag_d = flag_q;
    oflow_alert_d = oflow_alert_q;
    acc_clear_d = clr_cmd;
    refresh_d = any_cmd;
    if (wr_ctrl) begin
      rate_d = reg_wdata_i[`MMAC_BIT_RATE_HI:`MMAC_BIT_RATE_LO];
      halt_d = reg_wdata_i[`MMAC_BIT_HALT];
      single_d = reg_wdata_i[`MMAC_BIT_SINGLE];
      role_d = reg_wdata_i[`MMAC_BIT_ROLE];
      cc_en_d = reg_wdata_i[`MMAC_BIT_CC_EN];
      oflow_en_d = reg_wdata_i[`MMAC_BIT_OFLOW_EN];
    end
    // mode follows the commands; the keep command never clears
    if (any_cmd) begin
      if (halt_q) begin
        mode_d = MMAC_SLEEP;
      end else if (single_q) begin
        mode_d = MMAC_SINGLE;
      end else begin
        mode_d = MMAC_CONT;
      end
    end else if (mode_q == MMAC_SINGLE && conv_cycle_done_i) begin
      mode_d = MMAC_SLEEP;
    end
    // clearing commands drop flag and alert; a same-cycle overflow still sets the flag, and the alert if overflow is enabled
    if (clr_cmd) begin
      flag_d = 1'b0;
      oflow_alert_d = 1'b0;
    end
    if (acc_overflow_i) begin
      flag_d = 1'b1;
      if (oflow_en_q) begin
        oflow_alert_d = 1'b1;
      end
    end
    // reduced rate overrides the programmed field
    rate_eff_d = slow_active ? `MMAC_RATE_8 : rate_q;
    // open drain: drive low only as alert output, else release high
    oe_d = role_q & alert_active;
    rdata_d = 8'h00;
    if (reg_addr_i == `MMAC_CTRL_ADDR) begin
      rdata_d = {rate_q, halt_q, single_q, role_q, cc_en_q, oflow_en_q, flag_q};
    end
  end

  // registers only; device powers up converting continuously
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q <= MMAC_CONT;
      rate_q <= `MMAC_RATE_1024;
      halt_q <= 1'b0;
      single_q <= 1'b0;
      role_q <= 1'b0;
      cc_en_q <= 1'b0;
      oflow_en_q <= 1'b0;
      flag_q <= 1'b0;
      oflow_alert_q <= 1'b0;
      slow_s1_q <= 1'b0;
      slow_s2_q <= 1'b0;
      acc_clear_q <= 1'b0;
      refresh_q <= 1'b0;
      rate_eff_q <= `MMAC_RATE_1024;
      oe_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      mode_q <= mode_d;
      rate_q <= rate_d;
      halt_q <= halt_d;
      single_q <= single_d;
      role_q <= role_d;
      cc_en_q <= cc_en_d;
      oflow_en_q <= oflow_en_d;
      flag_q <= flag_d;
      oflow_alert_q <= oflow_alert_d;
      slow_s1_q <= shared_pin_i; // pin is asynchronous
      slow_s2_q <= slow_s1_q;
      acc_clear_q <= acc_clear_d;
      refresh_q <= refresh_d;
      rate_eff_q <= rate_eff_d;
      oe_q <= oe_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign alert_pin_o = 1'b0;
  assign alert_pin_oe_o = oe_q;
  assign conv_run_o = (mode_q != MMAC_SLEEP);
  assign conv_rate_o = rate_eff_q;
  assign acc_clear_o = acc_clear_q;
  assign results_refresh_o = refresh_q;

  // helper: length of each conversion-done pulse
  localparam int PULSE_CYC = `MMAC_PULSE_CYC;
  logic [`MMAC_TMR_W:0] len_q;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      len_q <= '0;
    end else if (conv_cycle_done_i & cc_en_q) begin
      len_q <= '0;
    end else if (cc_pulse) begin
      len_q <= len_q + 1'b1;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_single_sleep;
    mode_q == MMAC_SINGLE && conv_cycle_done_i && !any_cmd |=> mode_q == MMAC_SLEEP;
  endproperty
  a_single_sleep: assert property (p_single_sleep) else $error("single shot did not sleep");
  property p_single_again;
    cmd_clear_i && !halt_q && single_q |=> mode_q == MMAC_SINGLE && acc_clear_o;
  endproperty
  a_single_again: assert property (p_single_again) else $error("single shot not restarted");
  property p_cont;
    cmd_clear_i && !halt_q && !single_q |=> mode_q == MMAC_CONT && acc_clear_o && results_refresh_o;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous scan not started");
  property p_keep;
    cmd_keep_i && !clr_cmd |=> !acc_clear_o && results_refresh_o;
  endproperty
  a_keep: assert property (p_keep) else $error("keep command cleared accumulators");
  property p_role_off;
    !role_q |=> !alert_pin_oe_o;
  endproperty
  a_role_off: assert property (p_role_off) else $error("pin driven while an input");
  property p_pulse_len;
    $fell(cc_pulse) |-> $past(len_q) == PULSE_CYC - 1;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("done pulse length wrong");
  property p_prio;
    oflow_en_q && !oflow_alert_q |=> !alert_pin_oe_o;
  endproperty
  a_prio: assert property (p_prio) else $error("done pulse seen under overflow enable");
  // flag is looked at one cycle on, since a clear in the next cycle may drop it legally
  property p_oflow_pin;
    acc_overflow_i && oflow_en_q && role_q && !clr_cmd && !wr_ctrl |=> flag_q ##1 alert_pin_oe_o;
  endproperty
  a_oflow_pin: assert property (p_oflow_pin) else $error("overflow alert not driven");
  property p_oflow_hold;
    oflow_alert_q && !clr_cmd |=> oflow_alert_q;
  endproperty
  a_oflow_hold: assert property (p_oflow_hold) else $error("overflow alert dropped early");
  property p_flag_set;
    acc_overflow_i |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow flag not set");
  property p_flag_clr;
    clr_cmd && !acc_overflow_i |=> !flag_q && acc_clear_o;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared by command");
  property p_slow;
    slow_active |=> conv_rate_o == `MMAC_RATE_8;
  endproperty
  a_slow: assert property (p_slow) else $error("reduced rate not applied");
  property p_halt;
    any_cmd && halt_q |=> !conv_run_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not sleep");

  c_single_done: cover property (mode_q == MMAC_SINGLE ##[1:1000] mode_q == MMAC_SLEEP);
  c_cc_pulse: cover property (role_q && $rose(alert_pin_oe_o) && !oflow_en_q);
  c_oflow_alert: cover property (role_q && oflow_alert_q && alert_pin_oe_o ##1 clr_cmd);
endmodule

// ==== logic/mmac_pulse_timer.sv ====
`include "mmac_defines.svh"
module mmac_pulse_timer
  import mmac_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  output logic active_o
);
  logic [`MMAC_TMR_W-1:0] cnt_q;
  logic [`MMAC_TMR_W-1:0] cnt_d;

  // a new start reloads, so back-to-back completions stretch the pulse
  always_comb begin
    cnt_d = cnt_q;
    if (start_i) begin
      cnt_d = `MMAC_TMR_W'(`MMAC_PULSE_CYC);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - `MMAC_TMR_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign active_o = (cnt_q != '0);
endmodule

// ==== shared/mmac_defines.svh ====
// Operation
// - single-shot clear command: one cycle, then sleep
// - each further clear command repeats one cycle
// - continuous mode: clear command starts sequential scan
// - keep command switches modes, accumulators untouched
// - pin-role bit turns pin into alert output
// - conversion-done enable drives pin on completion
// - overflow enable drives pin on any overflow
// - pin-role bit never alters internal alert logic
// - pulled-up pin slows; role bit restores rate
// - conversion-done alert is 5 us pulse
// - overflow alert dominates, hides conversion-done pulses
// - overflow alert shows in flag; pin only if role
// - overflow alert holds until clear or broadcast
// - overflow flag sets on any overflow
// - only clearing commands clear flag and accumulators
// - rate field picks 1024/256/64/8 samples per second
// - halt bit forces sleep on next command
// - slow pin asserted forces 8 Hz rate
// - clear command refreshes results and resets accumulators in the same cycle
`ifndef MMAC_DEFINES_SVH
`define MMAC_DEFINES_SVH

`define MMAC_CTRL_ADDR 8'h01
`define MMAC_BIT_RATE_HI 7
`define MMAC_BIT_RATE_LO 6
`define MMAC_BIT_HALT 5
`define MMAC_BIT_SINGLE 4
`define MMAC_BIT_ROLE 3
`define MMAC_BIT_CC_EN 2
`define MMAC_BIT_OFLOW_EN 1
`define MMAC_BIT_FLAG 0
`define MMAC_RATE_1024 2'h0
`define MMAC_RATE_256 2'h1
`define MMAC_RATE_64 2'h2
`define MMAC_RATE_8 2'h3
`define MMAC_CLK_MHZ 125
`define MMAC_PULSE_NS 5000
`define MMAC_PULSE_CYC ((`MMAC_PULSE_NS * `MMAC_CLK_MHZ + 999) / 1000)
`define MMAC_TMR_W 10

`endif

// ==== shared/mmac_pkg.sv ====
package mmac_pkg;
  typedef enum logic [1:0] {
    MMAC_SLEEP,
    MMAC_SINGLE,
    MMAC_CONT
  } mmac_mode_t;
endpackage

// ==== testbench/mmac_ctrl_test.sv ====
module mmac_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, done, oflw, pin, flag_m;
  logic [7:0] ctrl_m;
  wire logic wr_s, clr, keep, bcast, run, aclr, rfsh, pin_o, oe;
  wire logic [7:0] addr, wdata, rdata;
  wire logic [1:0] rate;
  int errors, cmp_count, cyc, n;
  mmac_host_model host (.core_clk_i(clk), .wr_o(wr_s), .addr_o(addr), .wdata_o(wdata),
    .clr_o(clr), .keep_o(keep), .bcast_o(bcast));
  mmac_ctrl dut (.core_clk_i(clk), .rst_b_i(rst_b), .reg_wr_i(wr_s), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .cmd_clear_i(clr), .cmd_keep_i(keep),
    .cmd_bcast_i(bcast), .conv_cycle_done_i(done), .acc_overflow_i(oflw), .shared_pin_i(pin),
    .alert_pin_o(pin_o), .alert_pin_oe_o(oe), .conv_run_o(run), .conv_rate_o(rate),
    .acc_clear_o(aclr), .results_refresh_o(rfsh));
  // 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard; the whole run needs under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string s, input logic [15:0] v, input logic [15:0] e);
    cmp_count++;
    if (v !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // datapath events; the flag model sets on any overflow
  task automatic ev(input logic d, input logic o);
    step(1);
    done = d;
    oflw = o;
    flag_m = flag_m | o;
    step(1);
    {done, oflw} = 2'h0;
  endtask
  task automatic wr(input logic [7:0] d);
    host.wr_byte(8'h01, d);
    ctrl_m = {d[7:1], 1'b0};
  endtask
  task automatic c(input int k);
    host.cmd(k);
    if (k != 1) flag_m = 1'b0;
    check("aclr", aclr, k != 1);
    check("rfsh", rfsh, 1'b1);
  endtask
  task automatic ck_reg();
    check("ctrl", rdata, {ctrl_m[7:1], flag_m});
  endtask
  function automatic logic [1:0] exp_rate();
    return (!ctrl_m[3] && pin) ? 2'h3 : ctrl_m[7:6];
  endfunction
  initial begin
    rst_b = 1'b0;
    {done, oflw, pin, flag_m} = 4'h0;
    ctrl_m = 8'h00;
    n = $urandom(10897);
    step(12);
    rst_b = 1'b1;
    check("run", run, 1'b1);
    check("oe", oe, 1'b0);
    step(1);
    ck_reg();
    // every rate code, random pin level and other bits
    for (int i = 0; i < 8; i++) begin
      pin = 1'($urandom_range(1));
      wr({i[1:0], 6'($urandom_range(63))});
      step(4);
      ck_reg();
      check("rate", rate, exp_rate());
    end
    pin = 1'b0;
    host.wr_byte(8'h02, 8'hff);
    step(2);
    check("unmapped", rdata, 8'h00);
    // a write elsewhere must leave the rate field alone
    check("rate", rate, exp_rate());
    // single shot, repeat, keep into continuous, halt
    wr(8'h10);
    c(0);
    check("run", run, 1'b1);
    ev(1, 0);
    check("run", run, 1'b0);
    c(0);
    check("run", run, 1'b1);
    ev(1, 0);
    wr(8'h00);
    c(1);
    ev(1, 0);
    check("run", run, 1'b1);
    wr(8'h20);
    c(0);
    check("run", run, 1'b0);
    // done pulse only when the pin is an output
    wr(8'h04);
    ev(1, 0);
    step(3);
    check("oe", oe, 1'b0);
    wr(8'h0c);
    ev(1, 0);
    n = 0;
    repeat (700) begin
      step(1);
      n += (oe === 1'b1);
    end
    check("pulse", n, 625);
    check("pin", pin_o, 1'b0);
    check("oe", oe, 1'b0);
    // overflow dominates, latches, survives role and keep
    wr(8'h0e);
    ev(1, 0);
    step(3);
    check("oe", oe, 1'b0);
    ev(0, 1);
    step(1);
    check("oe", oe, 1'b1);
    ck_reg();
    wr(8'h06);
    step(2);
    check("oe", oe, 1'b0);
    wr(8'h0e);
    step(2);
    check("oe", oe, 1'b1);
    c(1);
    step(2);
    check("oe", oe, 1'b1);
    ck_reg();
    c(2);
    step(2);
    check("oe", oe, 1'b0);
    ck_reg();
    wr(8'h08);
    ev(0, 1);
    step(2);
    check("oe", oe, 1'b0);
    ck_reg();
    c(0);
    step(2);
    ck_reg();
    tally_and_finish();
  end
endmodule

// ==== testbench/mmac_host_model.sv ====
module mmac_host_model (
  input wire logic core_clk_i,
  output logic wr_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic clr_o,
  output logic keep_o,
  output logic bcast_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: address starts on the control register; a write leaves it on its own target
  initial begin
    {wr_o, clr_o, keep_o, bcast_o} = 4'h0;
    addr_o = 8'h01;
    wdata_o = 8'h00;
  end
  // one strobed byte; stale data inverted so it is never reused
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge core_clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  // send-byte command, no data: 0 clear, 1 keep, 2 broadcast
  task automatic cmd(input int k);
    @(posedge core_clk_i);
    #1;
    clr_o = (k == 0);
    keep_o = (k == 1);
    bcast_o = (k == 2);
    @(posedge core_clk_i);
    #1;
    {clr_o, keep_o, bcast_o} = 3'h0;
  endtask
endmodule
